/* lcd_mode_consts.svh */
// Constants of the display-mode instruction decoder: opcodes, register offsets, reset values
// and timing counts. Included by every design file that needs them.
`ifndef LCD_MODE_CONSTS_SVH
`define LCD_MODE_CONSTS_SVH

// Opcode patterns on the data byte, with both control lines low and write direction.
`define OP_DISPLAY_MODE 3'h1
`define OP_MOVE_ADDRESS 4'h1
`define OP_UNDERLINE_MODE 6'h03
`define OP_UNDERLINE_WRITE 6'h02
`define OP_BLINK_RATE 6'h01
`define OP_ADDRESS_HOME 8'h03
`define OP_CLEAR_HOME 8'h01

// Field positions inside the instruction data byte.
`define FLD_CSR_MOVE 3
`define FLD_CSR_DIR 2
`define FLD_DSP_MOVE 1
`define FLD_DSP_DIR 0
`define FLD_UL_ENABLE 1
`define FLD_UL_SELECT 0
`define FLD_UW_VALUE 1
`define FLD_UW_ADVANCE 0

// Display RAM.
`define RAM_WORDS 256
`define SPACE_CODE 8'h20
`define HOME_ADDR 8'h00

// APB register byte offsets.
`define REG_CMD 12'h000
`define REG_STATUS 12'h004
`define REG_ADDR 12'h008

// Reset values.
`define RST_MODE 5'h00
`define RST_BLINK 2'h0

// Timing: every simple instruction holds busy for this long.
`define EXEC_TIME_NS 40
`define CLK_PERIOD_NS 10
`define EXEC_CYCLES ((`EXEC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Oscillator clocks per blink period at the slowest blink code.
`define BLINK_DIV_DEFAULT 4718592

`endif

/* lcd_mode_pkg.sv */
// Types shared by the display-mode instruction decoder and its helpers.
// Assumes the constants header is compiled alongside.
package lcd_mode_pkg;

    typedef struct packed {
        logic ctrl_one;
        logic ctrl_two;
        logic read_dir;
        logic [7:0] data;
    } instr_type;

    typedef struct packed {
        logic display_on;
        logic cursor_visible;
        logic underline_visible;
        logic cursor_blink_enable;
        logic char_blink_enable;
    } mode_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_CLEAR = 3'b100
    } exec_state_type;

endpackage

/* lcd_pin_sync.sv */
// Two-stage synchroniser for the host instruction pins.
// Assumes the pins are asynchronous to pclk.
`timescale 1ns/10ps
`default_nettype none

module lcd_pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] pins,
    output logic [11:0] pins_sync
);
    logic [11:0] stage_one_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage_one_q <= 12'h000;
            pins_sync <= 12'h000;
        end
        else
        begin
            stage_one_q <= pins;
            pins_sync <= stage_one_q;
        end
    end
endmodule

`default_nettype wire

/* lcd_blink_timer.sv */
// Blink phase generator: toggles the phase once per half blink period.
// Assumes pclk is the oscillator clock; the divider is shortened in simulation.
`timescale 1ns/10ps
`default_nettype none
`include "lcd_mode_consts.svh"

module lcd_blink_timer #(
    parameter int unsigned BLINK_DIV = `BLINK_DIV_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] blink_code,
    output logic blink_phase
);
    localparam int unsigned HALF = BLINK_DIV / 2;
    localparam logic [22:0] HALF_LAST = 23'(HALF - 1);

    logic [22:0] count_q;
    logic [22:0] limit;

    // Each code step doubles the rate, so the half period shrinks by a shift.
    assign limit = HALF_LAST >> blink_code;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= 23'h00_0000;
            blink_phase <= 1'b1;
        end
        else if (count_q >= limit)
        begin
            count_q <= 23'h00_0000;
            blink_phase <= ~blink_phase;
        end
        else
        begin
            count_q <= count_q + 23'h00_0001;
        end
    end
endmodule

`default_nettype wire

/* lcd_mode_core.sv */
// Display-mode instruction decoder with display RAM, scan output and APB status port.
// Assumes a host on pins asynchronous to pclk and software on an APB bus on pclk.
//
// What this block does
// - Control lines low, data 001xxxxx: latch display mode flags from low bits.
// - Display flag 1 shows content; 0 sets char blank, clears underline and cursor, scan_char still reads RAM.
// - Cursor line drawn only while cursor-visible flag is 1.
// - Underlines show for marked words only while underline-display flag is 1.
// - Cursor-blink flag 1 toggles cursor line at blink rate, else steady.
// - Character-blink flag 1 blinks the character under the cursor.
// - Data 0001xxxx moves cursor and display start addresses independently.
// - Cursor move enabled: direction 1 decrements, 0 increments; else unchanged.
// - Display move enabled: start address steps by one; else unchanged.
// - Data 000011xx: enable 1 lets data writes set or clear underline per select.
// - Marked words in underline mode get a bottom-row underline beside the character.
// - Data 000010xx writes bit 1 into the underline bit at cursor address.
// - Underline write with bit 0 set increments cursor afterwards.
// - Blink code picks oscillator over 4718592, times 1, 2, 4 or 8.
// - Address home zeroes display start and cursor addresses only.
// - Clear home fills characters with space, clears underlines, zeroes addresses.
// - While executing, busy reads 1 and other non-read instructions are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "lcd_mode_consts.svh"

module lcd_mode_core #(
    parameter int unsigned BLINK_DIV = `BLINK_DIV_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic execute_strobe,
    input wire logic instr_ctrl_line_one,
    input wire logic instr_ctrl_line_two,
    input wire logic read_write,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic busy,
    output logic [7:0] scan_char,
    output logic scan_char_blank,
    output logic scan_underline,
    output logic scan_cursor
);
    localparam logic [3:0] EXEC_LAST = 4'(`EXEC_CYCLES - 1);

    // Sees whether an instruction byte carries the given opcode in its top bits.
    function automatic logic op_is(input logic [7:0] data, input logic [7:0] pattern,
                                   input int unsigned width);
        logic [7:0] mask;
        mask = 8'hFF << (8 - width);
        op_is = (data & mask) == (pattern << (8 - width));
    endfunction

    // One step of an address: direction 1 goes down, 0 goes up.
    function automatic logic [7:0] addr_step(input logic [7:0] addr, input logic dir);
        addr_step = dir ? addr - 8'h01 : addr + 8'h01;
    endfunction

    // Host pins, synchronised.
    logic [11:0] pins_sync;
    logic strobe_s;
    logic strobe_prev_q;
    lcd_mode_pkg::instr_type pin_instr;

    lcd_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins({execute_strobe, instr_ctrl_line_one, instr_ctrl_line_two, read_write, data_in}),
        .pins_sync(pins_sync)
    );

    assign strobe_s = pins_sync[11];
    assign pin_instr = pins_sync[10:0];

    // Execution state.
    lcd_mode_pkg::exec_state_type state_q;
    lcd_mode_pkg::mode_type mode_q;
    logic [1:0] blink_code_q;
    logic underline_auto_enable_q;
    logic underline_value_select_q;
    logic [7:0] cursor_q;
    logic [7:0] start_q;
    logic [3:0] hold_q;
    logic [7:0] clear_idx_q;
    logic apb_pending_q;
    lcd_mode_pkg::instr_type apb_instr_q;

    // Display RAM kept as character and underline planes of one nine-bit word.
    logic [7:0] char_mem [0:`RAM_WORDS-1];
    logic under_mem [0:`RAM_WORDS-1];

    // Instruction selection: a pin strobe wins, a queued software instruction waits for it.
    logic pin_event;
    logic take_apb;
    logic have_instr;
    lcd_mode_pkg::instr_type instr;
    logic is_ctrl_cmd;
    logic is_flag_read;
    logic accept;

    assign pin_event = strobe_s & ~strobe_prev_q;
    assign take_apb = apb_pending_q & ~pin_event;
    assign have_instr = pin_event | take_apb;
    assign instr = pin_event ? pin_instr : apb_instr_q;
    assign is_ctrl_cmd = ~instr.ctrl_one & ~instr.ctrl_two & ~instr.read_dir;
    assign is_flag_read = ~instr.ctrl_one & ~instr.ctrl_two & instr.read_dir;
    // Busy blocks every instruction except the flag read.
    assign accept = have_instr & ~is_flag_read & (state_q == lcd_mode_pkg::ST_IDLE);

    logic display_mode_cmd;
    logic move_address_cmd;
    logic underline_mode_cmd;
    logic underline_write_cmd;
    logic blink_rate_cmd;
    logic address_home_cmd;
    logic clear_home_cmd;
    logic ram_write_cmd;

    assign display_mode_cmd = accept & is_ctrl_cmd
        & op_is(instr.data, 8'(`OP_DISPLAY_MODE), 3);
    assign move_address_cmd = accept & is_ctrl_cmd
        & op_is(instr.data, 8'(`OP_MOVE_ADDRESS), 4);
    assign underline_mode_cmd = accept & is_ctrl_cmd
        & op_is(instr.data, 8'(`OP_UNDERLINE_MODE), 6);
    assign underline_write_cmd = accept & is_ctrl_cmd
        & op_is(instr.data, 8'(`OP_UNDERLINE_WRITE), 6);
    assign blink_rate_cmd = accept & is_ctrl_cmd & op_is(instr.data, 8'(`OP_BLINK_RATE), 6);
    assign address_home_cmd = accept & is_ctrl_cmd & (instr.data == `OP_ADDRESS_HOME);
    assign clear_home_cmd = accept & is_ctrl_cmd & (instr.data == `OP_CLEAR_HOME);
    assign ram_write_cmd = accept & instr.ctrl_one & ~instr.ctrl_two & ~instr.read_dir;

    // Next address values.
    logic [7:0] cursor_d;
    logic [7:0] start_d;
    logic clear_last;

    assign clear_last = clear_idx_q == 8'(`RAM_WORDS - 1);

    always_comb
    begin
        cursor_d = cursor_q;
        start_d = start_q;
        if (move_address_cmd)
        begin
            if (instr.data[`FLD_CSR_MOVE])
                cursor_d = addr_step(cursor_q, instr.data[`FLD_CSR_DIR]);
            if (instr.data[`FLD_DSP_MOVE])
                start_d = addr_step(start_q, instr.data[`FLD_DSP_DIR]);
        end
        else if (underline_write_cmd & instr.data[`FLD_UW_ADVANCE])
        begin
            cursor_d = cursor_q + 8'h01;
        end
        else if (ram_write_cmd)
        begin
            cursor_d = cursor_q + 8'h01;
        end
        else if (address_home_cmd)
        begin
            cursor_d = `HOME_ADDR;
            start_d = `HOME_ADDR;
        end
        else if ((state_q == lcd_mode_pkg::ST_CLEAR) && clear_last)
        begin
            cursor_d = `HOME_ADDR;
            start_d = `HOME_ADDR;
        end
    end

    // Instruction sequencer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= lcd_mode_pkg::ST_IDLE;
            hold_q <= 4'h0;
            clear_idx_q <= 8'h00;
            strobe_prev_q <= 1'b0;
        end
        else
        begin
            strobe_prev_q <= strobe_s;
            unique case (state_q)
                lcd_mode_pkg::ST_IDLE:
                begin
                    hold_q <= EXEC_LAST;
                    clear_idx_q <= 8'h00;
                    if (clear_home_cmd)
                        state_q <= lcd_mode_pkg::ST_CLEAR;
                    else if (accept)
                        state_q <= lcd_mode_pkg::ST_HOLD;
                end
                lcd_mode_pkg::ST_HOLD:
                begin
                    hold_q <= hold_q - 4'h1;
                    if (hold_q == 4'h0)
                        state_q <= lcd_mode_pkg::ST_IDLE;
                end
                lcd_mode_pkg::ST_CLEAR:
                begin
                    clear_idx_q <= clear_idx_q + 8'h01;
                    if (clear_last)
                        state_q <= lcd_mode_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Mode flags and addresses.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= `RST_MODE;
            blink_code_q <= `RST_BLINK;
            underline_auto_enable_q <= 1'b0;
            underline_value_select_q <= 1'b0;
            cursor_q <= `HOME_ADDR;
            start_q <= `HOME_ADDR;
        end
        else
        begin
            cursor_q <= cursor_d;
            start_q <= start_d;
            if (display_mode_cmd)
                mode_q <= instr.data[4:0];
            if (blink_rate_cmd)
                blink_code_q <= instr.data[1:0];
            if (underline_mode_cmd)
            begin
                underline_auto_enable_q <= instr.data[`FLD_UL_ENABLE];
                underline_value_select_q <= instr.data[`FLD_UL_SELECT];
            end
        end
    end

    // Display RAM writes; the clear sweep owns the RAM while it runs.
    always_ff @(posedge pclk)
    begin
        if (state_q == lcd_mode_pkg::ST_CLEAR)
        begin
            char_mem[clear_idx_q] <= `SPACE_CODE;
            under_mem[clear_idx_q] <= 1'b0;
        end
        else if (ram_write_cmd)
        begin
            char_mem[cursor_q] <= instr.data;
            if (underline_auto_enable_q)
                under_mem[cursor_q] <= underline_value_select_q;
        end
        else if (underline_write_cmd)
        begin
            under_mem[cursor_q] <= instr.data[`FLD_UW_VALUE];
        end
    end

    // Blink phase for cursor and character blinking.
    logic blink_phase;

    lcd_blink_timer #(
        .BLINK_DIV(BLINK_DIV)
    ) u_blink (
        .pclk(pclk),
        .presetn(presetn),
        .blink_code(blink_code_q),
        .blink_phase(blink_phase)
    );

    // Scan: walks the RAM from the display start address, one word per clock.
    logic [7:0] scan_idx_q;
    logic [7:0] scan_addr;
    logic at_cursor;
    logic cursor_lit;
    logic char_hidden;

    assign scan_addr = start_q + scan_idx_q;
    assign at_cursor = scan_addr == cursor_q;
    assign cursor_lit = mode_q.cursor_visible
        & (~mode_q.cursor_blink_enable | blink_phase);
    assign char_hidden = mode_q.char_blink_enable & at_cursor & ~blink_phase;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_idx_q <= 8'h00;
            scan_char <= `SPACE_CODE;
            scan_char_blank <= 1'b1;
            scan_underline <= 1'b0;
            scan_cursor <= 1'b0;
        end
        else
        begin
            scan_idx_q <= scan_idx_q + 8'h01;
            scan_char <= char_mem[scan_addr];
            // Display off sets the blank flag and clears underline and cursor; scan_char keeps the RAM word.
            scan_char_blank <= ~mode_q.display_on | char_hidden;
            scan_underline <= mode_q.display_on & mode_q.underline_visible
                & under_mem[scan_addr];
            scan_cursor <= mode_q.display_on & at_cursor & cursor_lit;
        end
    end

    // Flag read on the host data pins and the busy output.
    logic [7:0] flag_byte;
    logic host_reading;

    assign flag_byte = {state_q != lcd_mode_pkg::ST_IDLE, mode_q, blink_code_q};
    assign host_reading = strobe_s & ~pin_instr.ctrl_one & ~pin_instr.ctrl_two
        & pin_instr.read_dir;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            data_out <= flag_byte;
            data_oe <= host_reading;
            busy <= (state_q != lcd_mode_pkg::ST_IDLE) | accept;
        end
    end

    // APB slave: one wait state, so every output comes from a flop.
    logic apb_access;
    logic apb_done;
    logic hit_cmd;
    logic hit_status;
    logic hit_addr;
    logic [31:0] read_word;

    assign apb_access = psel & penable & ~pready;
    assign apb_done = psel & penable & pready;
    assign hit_cmd = paddr == `REG_CMD;
    assign hit_status = paddr == `REG_STATUS;
    assign hit_addr = paddr == `REG_ADDR;
    assign read_word = hit_status ? {18'h0_0000, underline_auto_enable_q,
                                     underline_value_select_q, 4'h0, flag_byte}
                     : hit_addr ? {16'h0000, start_q, cursor_q}
                     : hit_cmd ? {21'h00_0000, apb_instr_q}
                     : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            apb_pending_q <= 1'b0;
            apb_instr_q <= 11'h000;
        end
        else
        begin
            pready <= apb_access;
            pslverr <= apb_access & ~(hit_cmd | hit_status | hit_addr);
            prdata <= (apb_access & ~pwrite) ? read_word : 32'h0000_0000;
            if (apb_done & pwrite & hit_cmd & ~apb_pending_q)
            begin
                apb_pending_q <= 1'b1;
                apb_instr_q <= pwdata[10:0];
            end
            else if (take_apb)
            begin
                apb_pending_q <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* lcd_mode_core_assertions.sv */
// Checker for the display-mode decoder: APB handshake, busy hold and flag-read drive.
// Assumes it is bound to lcd_mode_core and sees that module's ports only.
`timescale 1ns/10ps
`default_nettype none

module lcd_mode_core_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic execute_strobe,
    input wire logic read_write,
    input wire logic data_oe,
    input wire logic busy
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_one_wait: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("pready late or missing");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero while idle");
    a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("pslverr without pready or with data");
    a_busy_min_hold: assert property ($rose(busy) |-> busy [*4])
        else $error("busy dropped early");
    a_busy_bounded: assert property ($rose(busy) |-> ##[4:257] !busy)
        else $error("busy held too long");
    // The bus is only turned round for a flag read, never for an instruction.
    a_oe_read_only: assert property ($rose(data_oe) |->
        $past(execute_strobe, 2) && $past(read_write, 2))
        else $error("data bus driven without a flag read");
    a_oe_release: assert property ($fell(data_oe) |-> !$past(execute_strobe, 2))
        else $error("data bus released while strobe high");
endmodule

bind lcd_mode_core lcd_mode_core_checker chk (.pclk, .presetn, .psel, .penable, .prdata,
    .pready, .pslverr, .execute_strobe, .read_write, .data_oe, .busy);

`default_nettype wire

/* host_pin_model.sv */
// Host model: drives the instruction pins and polls busy with flag reads before each command.
// Assumes the bench resolves the shared data bus into data_in and pulses go for one cycle.
`timescale 1ns/10ps
`default_nettype none

module host_pin_model (
    input wire logic pclk,
    input wire logic go,
    input wire lcd_mode_pkg::instr_type instr,
    input wire logic [7:0] data_in,
    output logic done,
    output logic [7:0] flags,
    output logic execute_strobe,
    output logic instr_ctrl_line_one,
    output logic instr_ctrl_line_two,
    output logic read_write,
    output logic [7:0] data_drive
);
    lcd_mode_pkg::instr_type req;

    initial
    begin
        {done, execute_strobe, instr_ctrl_line_one, instr_ctrl_line_two, read_write} = '0;
        data_drive = 8'h00;
        flags = 8'h00;
    end

    // Each level is held five edges so the two-flop synchroniser cannot miss it.
    task automatic strobe(input lcd_mode_pkg::instr_type ins);
        // Whole bytes only: control lines stay fixed for the full strobe, no nibble halves.
        instr_ctrl_line_one <= ins.ctrl_one;
        instr_ctrl_line_two <= ins.ctrl_two;
        read_write <= ins.read_dir;
        data_drive <= ins.read_dir ? ~data_drive : ins.data;
        execute_strobe <= 1'b1;
        repeat (5) @(posedge pclk);
        if (ins.read_dir)
            flags <= data_in;
        execute_strobe <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    always @(posedge pclk)
    begin
        if (go)
        begin
            req = instr;
            do
                strobe(11'h100);
            while (flags[7] !== 1'b0);
            strobe(req);
            done <= 1'b1;
            @(posedge pclk);
            done <= 1'b0;
        end
    end
endmodule

`default_nettype wire

/* lcd_display_mode_commands_bench.sv */
// Self-checking bench: host pin model for instructions, APB reads for state, scan counts.
// Assumes the constants header, the package and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "lcd_mode_consts.svh"

module lcd_display_mode_commands_bench;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, er, go, done, busy, data_oe;
    logic execute_strobe, instr_ctrl_line_one, instr_ctrl_line_two, read_write;
    logic scan_char_blank, scan_underline, scan_cursor;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] data_in, data_out, data_drive, flags, scan_char, cur, st;
    lcd_mode_pkg::instr_type instr;
    int num_errors = 0;
    int samples_checked = 0;
    int ul, cu, bl, ot;
    logic [7:0] modes [6] = '{8'h3C, 8'h38, 8'h34, 8'h2C, 8'h3E, 8'h3D};
    int exp_cnt [6][3] = '{'{1, 1, 0}, '{0, 1, 0}, '{1, 0, 0}, '{0, 0, 256}, '{1, -1, 0},
                           '{1, 1, -1}};
    logic [7:0] moves [10] = '{8'h18, 8'h1C, 8'h1C, 8'h12, 8'h13, 8'h13, 8'h1A, 8'h15, 8'h10,
                               8'h1F};
    logic [7:0] ulm [3] = '{8'h0F, 8'h0E, 8'h0C};

    always #5 pclk = ~pclk;
    assign data_in = data_oe ? data_out : data_drive;

    lcd_mode_core #(.BLINK_DIV(64)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .execute_strobe, .instr_ctrl_line_one,
        .instr_ctrl_line_two, .read_write, .data_in, .data_out, .data_oe, .busy, .scan_char,
        .scan_char_blank, .scan_underline, .scan_cursor);
    host_pin_model host (.pclk, .go, .instr, .data_in, .done, .flags, .execute_strobe,
        .instr_ctrl_line_one, .instr_ctrl_line_two, .read_write, .data_drive);

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic reg_check(input string name, input logic [11:0] a, input logic [31:0] mask,
                             input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, exp, rd & mask);
    endtask

    task automatic host_cmd(input logic [10:0] v);
        instr <= v;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        do
            @(posedge pclk);
        while (done !== 1'b1);
    endtask

    task automatic wait_idle();
        do
            apb(1'b0, `REG_STATUS, 32'h0000_0000);
        while (rd[7] !== 1'b0);
    endtask

    // One full pass of the free-running scan index visits every word exactly once.
    task automatic sweep();
        {ul, cu, bl, ot} = '0;
        repeat (256)
        begin
            @(posedge pclk);
            ul += (scan_underline !== 1'b0);
            cu += (scan_cursor !== 1'b0);
            bl += (scan_char_blank !== 1'b0);
            ot += (scan_char !== 8'h20);
        end
    endtask

    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        {psel, penable, pwrite, go} = '0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        instr = 11'h000;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        reg_check("status_rst", `REG_STATUS, 32'h0000_3FFF, 32'h0000_0000);
        reg_check("addr_rst", `REG_ADDR, 32'h0000_FFFF, 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        check("unmapped_err", 32'h0000_0001, {31'h0, er});
        host_cmd(11'h03C);
        host_cmd(11'h001);
        reg_check("clear_busy", `REG_STATUS, 32'h0000_0080, 32'h0000_0080);
        check("busy_pin", 32'h0000_0001, {31'h0, busy});
        wait_idle();
        check("busy_idle", 32'h0000_0000, {31'h0, busy});
        reg_check("clear_addr", `REG_ADDR, 32'h0000_FFFF, 32'h0000_0000);
        sweep();
        check("clear_chars", 32'h0000_0000, ot);
        check("clear_ul", 32'h0000_0000, ul);
        host_cmd(11'h00B);
        reg_check("ulw_adv", `REG_ADDR, 32'h0000_FFFF, 32'h0000_0001);
        for (int i = 0; i < 6; i++)
        begin
            host_cmd({3'b000, modes[i]});
            host_cmd(11'h100);
            check("flag_mode", {27'h0, modes[i][4:0]}, {27'h0, flags[6:2]});
            reg_check("status_mode", `REG_STATUS, 32'h0000_007C,
                      {25'h0, modes[i][4:0], 2'b00});
            sweep();
            check("ul_count", exp_cnt[i][0], ul);
            if (exp_cnt[i][1] >= 0)
                check("cursor_count", exp_cnt[i][1], cu);
            if (exp_cnt[i][2] >= 0)
                check("blank_count", exp_cnt[i][2], bl);
        end
        for (int c = 0; c < 4; c++)
        begin
            host_cmd({9'h001, c[1:0]});
            reg_check("blink_code", `REG_STATUS, 32'h0000_0003, c);
        end
        for (int u = 0; u < 3; u++)
        begin
            host_cmd({3'b000, ulm[u]});
            reg_check("ul_mode", `REG_STATUS, 32'h0000_3000,
                      {18'h0, ulm[u][1:0], 12'h000});
        end
        // With underline set mode on, a data write at cursor 1 marks that word as well.
        host_cmd(11'h00F);
        host_cmd(11'h441);
        sweep();
        check("wd_ul", 32'h0000_0002, ul);
        check("wd_char", 32'h0000_0001, ot);
        host_cmd(11'h003);
        reg_check("home_addr", `REG_ADDR, 32'h0000_FFFF, 32'h0000_0000);
        reg_check("home_keeps", `REG_STATUS, 32'h0000_00FF, 32'h0000_0077);
        cur = 8'h00;
        st = 8'h00;
        foreach (moves[i])
        begin
            host_cmd({3'b000, moves[i]});
            if (moves[i][3])
                cur = moves[i][2] ? cur - 8'h01 : cur + 8'h01;
            if (moves[i][1])
                st = moves[i][0] ? st - 8'h01 : st + 8'h01;
            reg_check("move_addr", `REG_ADDR, 32'h0000_FFFF, {16'h0000, st, cur});
        end
        for (int d = 8; d < 12; d++)
        begin
            host_cmd(11'(d));
            cur = cur + {7'h00, d[0]};
            reg_check("ulw_addr", `REG_ADDR, 32'h0000_FFFF, {16'h0000, st, cur});
        end
        // The second command lands while the first still executes and must be lost.
        apb(1'b1, `REG_CMD, 32'h0000_0018);
        apb(1'b1, `REG_CMD, 32'h0000_0018);
        wait_idle();
        cur = cur + 8'h01;
        reg_check("busy_drop", `REG_ADDR, 32'h0000_FFFF, {16'h0000, st, cur});
        final_report();
    end

    initial
    begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        final_report();
    end
endmodule

`default_nettype wire
